// ---- rtl/can_msgbuf_params.svh ----
// offsets, field positions and reset values of the message buffer manager
// Summary of operation
// R1: stamp acknowledged frames with timer when enabled
// R2: software reads tx stamp after buffer empty
// R3: timer free-runs on bit ticks, wraps silently
// R4: timer held zero in initialization mode
// R5: stamp registers read-only, readable when buffer empty
// R6: three tx buffers: 13 bytes, priority, stamp
// R7: software selects an empty buffer into window
// R8: software hands buffer over by clearing empty
// R9: successful send sets empty flag, tx event
// R10: lowest priority value wins every arbitration attempt
// R11: abort request granted unless buffer is sending
// R12: abort ack shows cancelled one, sent zero
// R13: five-entry rx fifo, foreground only visible
// R14: rx entry fifteen bytes including stamp
// R15: rx full flag while foreground holds message
// R16: accepted valid frame pushed, flag, rx event
// R17: software reads foreground then clears full flag
// R18: bad or rejected frame never enters fifo
// R19: own frames not pushed nor acknowledged
// R20: loopback treats own frames like foreign ones
// R21: lost arbitration continues as normal receiver
// R22: full fifo drops frame, overrun flag, event
// R23: equal priorities resolved toward lower index
`ifndef CAN_MSGBUF_PARAMS_SVH
`define CAN_MSGBUF_PARAMS_SVH
`define OFS_CTRL 8'h00
`define OFS_TX_FLAG 8'h04
`define OFS_ABORT_REQ 8'h08
`define OFS_ABORT_ACK 8'h0c
`define OFS_TX_SELECT 8'h10
`define OFS_RX_FLAG 8'h14
`define OFS_TX_WIN 8'h40
`define OFS_TX_LOCAL_PRIORITY_FIELD 8'h50
`define OFS_STAMP_HIGH 8'h54
`define OFS_STAMP_LOW 8'h58
`define OFS_RX_WIN 8'h80
`define PAGE_MASK 8'hf0
`define RX_FULL_BIT 0
`define OVERRUN_BIT 1
`define TX_EMPTY_RST 3'h7
`define CTRL_RST 8'h01
`define RX_DEPTH 3'h5
`define TX_FRAME_BYTES 13
`define RX_STAMP_BYTE 13
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- rtl/can_msgbuf_pkg.sv ----
// types shared by the message buffer manager
package can_msgbuf_pkg;
  typedef struct packed {
    logic [1:0] spare;
    logic ovr_ie;
    logic rx_ie;
    logic tx_ie;
    logic loopback;
    logic stamp_en;
    logic init_mode;
  } ctrl_raw_t;
  typedef struct packed {
    logic [2:0] spare;
    logic ovr_ie;
    logic rx_ie;
    logic tx_ie;
    logic loopback;
    logic stamp_en;
  } ctrl_t;
  typedef struct packed {
    logic valid;
    logic [3:0] idx;
    logic [7:0] data;
  } rx_byte_t;
  typedef struct packed {
    logic valid;
    logic [1:0] idx;
    logic [103:0] frame;
  } tx_offer_t;
  typedef struct packed {
    logic [15:0] stamp;
    logic [103:0] frame;
  } rx_entry_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_BUSY = 2'b10
  } tx_state_t;
endpackage

// ---- rtl/can_message_buffer_manager.sv ----
// tx buffers, rx fifo and stamping behind an axi4-lite register slave
`timescale 1ns/1ps
`include "can_msgbuf_params.svh"
module can_message_buffer_manager import can_msgbuf_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bit_tick,
  input wire logic arb_slot,
  input wire logic tx_sent,
  input wire logic tx_retry,
  input wire rx_byte_t rx_byte,
  input wire logic rx_frame_ok,
  input wire logic rx_accept,
  input wire logic rx_own,
  output tx_offer_t tx_offer,
  output logic rx_ack_enable,
  output logic tx_event,
  output logic rx_event,
  output logic overrun_event
);
  ctrl_raw_t ctrl, next_ctrl;
  logic [2:0] tx_buffer_empty_flag, next_empty;
  logic [2:0] abort_request_bit, next_abort_req;
  logic [2:0] abort_ack_flag, next_abort_ack;
  logic [2:0] tx_buffer_select_reg, next_sel;
  logic [31:0] tx_mem [3][4];
  logic [31:0] next_tx_mem [3][4];
  logic [7:0] local_priority_field [3];
  logic [7:0] next_local_priority_field [3];
  logic [15:0] tx_stamp [3];
  logic [15:0] next_tx_stamp [3];
  tx_state_t tx_state, next_tx_state;
  logic [1:0] cur_idx, next_cur_idx;
  tx_offer_t next_offer;
  logic [15:0] timer, next_timer;
  logic [7:0] rx_background_entry [13];
  logic [7:0] next_bg [13];
  rx_entry_t fifo [5];
  rx_entry_t next_fifo [5];
  logic [2:0] rd_ptr, next_rd_ptr, wr_ptr, next_wr_ptr, count, next_count;
  logic overrun_flag, next_overrun;
  logic aw_full, next_aw_full, w_full, next_w_full;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] next_bresp, next_rresp;
  logic next_bvalid, next_rvalid;
  logic [31:0] next_rdata;
  logic next_tx_event, next_rx_event, next_ovr_event;
  logic [1:0] sel_idx;
  logic sel_ok, rx_full_flag, wr_fire;
  rx_entry_t fg;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = data[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] lowest_bit(input logic [2:0] v);
    return v & (~v + 3'h1);
  endfunction

  function automatic logic [2:0] ptr_inc(input logic [2:0] p);
    return (p == `RX_DEPTH - 3'h1) ? 3'h0 : p + 3'h1;
  endfunction

  // one-hot selection to index; an empty selection leaves the window dead
  always_comb begin
    sel_idx = tx_buffer_select_reg[2] ? 2'h2 :
              tx_buffer_select_reg[1] ? 2'h1 : 2'h0;
  end
  assign sel_ok = |(tx_buffer_select_reg & tx_buffer_empty_flag); // [R5]
  assign rx_full_flag = (count != 3'h0); // [R15]
  assign fg = fifo[rd_ptr]; // [R13]
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  // own frames go unacknowledged except in loopback
  assign rx_ack_enable = (tx_state != TX_BUSY) || ctrl.loopback; // [R19] [R20]

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for bus, transmit side, timer and receive fifo
  always_comb begin
    logic [1:0] best;
    logic best_ok, push, pop, drop;
    logic [2:0] set_empty;
    logic [7:0] wa, ra;
    logic [119:0] flat;
    best = 2'h0;
    best_ok = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    drop = 1'b0;
    set_empty = 3'h0;
    wa = {aw_addr[7:2], 2'b00};
    ra = {s_axi_araddr[7:2], 2'b00};
    flat = {fg.stamp, fg.frame};
    next_ctrl = ctrl;
    next_empty = tx_buffer_empty_flag;
    next_abort_req = abort_request_bit;
    next_abort_ack = abort_ack_flag;
    next_sel = tx_buffer_select_reg;
    next_tx_mem = tx_mem;
    next_local_priority_field = local_priority_field;
    next_tx_stamp = tx_stamp;
    next_tx_state = tx_state;
    next_cur_idx = cur_idx;
    next_offer = tx_offer;
    next_bg = rx_background_entry;
    next_fifo = fifo;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_count = count;
    next_overrun = overrun_flag;
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    // the timer never flags its wrap; software sees only the count
    next_timer = ctrl.init_mode ? 16'h0000 : timer + {15'h0000, bit_tick}; // [R3] [R4]
    // write channels are latched separately, so either may come first
    if (s_axi_awvalid && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `RESP_OKAY;
      if ((wa & `PAGE_MASK) == `OFS_TX_WIN) begin
        if (sel_ok) begin
          next_tx_mem[sel_idx][wa[3:2]] = merge(tx_mem[sel_idx][wa[3:2]],
            w_data, (wa[3:2] == 2'h3) ? {3'h0, w_strb[0]} : w_strb); // [R6]
        end
      end else begin
        case (wa)
          `OFS_CTRL: begin
            if (w_strb[0]) begin
              next_ctrl = ctrl_raw_t'(w_data[7:0]);
            end
          end
          `OFS_TX_FLAG: begin
            // a one hands the buffer over; its abort ack starts fresh
            if (w_strb[0]) begin
              next_empty = tx_buffer_empty_flag & ~w_data[2:0]; // [R8]
              next_abort_ack = abort_ack_flag &
                               ~(w_data[2:0] & tx_buffer_empty_flag);
            end
          end
          `OFS_ABORT_REQ: begin
            if (w_strb[0]) begin
              next_abort_req = abort_request_bit |
                               (w_data[2:0] & ~tx_buffer_empty_flag); // [R11]
            end
          end
          `OFS_TX_SELECT: begin
            // only an empty buffer can be picked, lowest one first
            if (w_strb[0]) begin
              next_sel = lowest_bit(w_data[2:0] & tx_buffer_empty_flag); // [R7]
            end
          end
          `OFS_RX_FLAG: begin
            if (w_strb[0] && w_data[`RX_FULL_BIT] && rx_full_flag) begin
              pop = 1'b1; // [R17]
            end
            if (w_strb[0] && w_data[`OVERRUN_BIT]) begin
              next_overrun = 1'b0;
            end
          end
          `OFS_TX_LOCAL_PRIORITY_FIELD: begin
            if (sel_ok && w_strb[0]) begin
              next_local_priority_field[sel_idx] = w_data[7:0];
            end
          end
          `OFS_ABORT_ACK, `OFS_STAMP_HIGH, `OFS_STAMP_LOW: begin
            next_bresp = `RESP_OKAY; // read-only, write dropped [R5]
          end
          default: begin
            next_bresp = `RESP_SLVERR;
          end
        endcase
      end
    end
    // read path answers one cycle after the address is taken
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_axi_rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = `RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if ((ra & `PAGE_MASK) == `OFS_TX_WIN) begin
        next_rdata = sel_ok ? tx_mem[sel_idx][ra[3:2]] : 32'h0000_0000;
      end else if ((ra & `PAGE_MASK) == `OFS_RX_WIN) begin
        if (rx_full_flag) begin
          next_rdata = (ra[3:2] == 2'h3) ? {8'h00, flat[119:96]} :
                       flat[32*ra[3:2] +: 32]; // [R14]
        end
      end else begin
        case (ra)
          `OFS_CTRL: next_rdata = {24'h000000, ctrl};
          `OFS_TX_FLAG: next_rdata = {29'h0, tx_buffer_empty_flag};
          `OFS_ABORT_REQ: next_rdata = {29'h0, abort_request_bit};
          `OFS_ABORT_ACK: next_rdata = {29'h0, abort_ack_flag};
          `OFS_TX_SELECT: next_rdata = {29'h0, tx_buffer_select_reg};
          `OFS_RX_FLAG: next_rdata = {30'h0, overrun_flag, rx_full_flag};
          `OFS_TX_LOCAL_PRIORITY_FIELD: begin
            next_rdata = sel_ok ? {24'h0, local_priority_field[sel_idx]} :
                         32'h0000_0000;
          end
          `OFS_STAMP_HIGH: begin
            next_rdata = sel_ok ? {24'h0, tx_stamp[sel_idx][15:8]} :
                         32'h0000_0000; // [R5]
          end
          `OFS_STAMP_LOW: begin
            next_rdata = sel_ok ? {24'h0, tx_stamp[sel_idx][7:0]} :
                         32'h0000_0000; // [R5]
          end
          default: next_rresp = `RESP_SLVERR;
        endcase
      end
    end
    // pick the pending buffer with the smallest priority value
    for (int i = 0; i < 3; i++) begin
      if (!tx_buffer_empty_flag[i] && !(abort_request_bit[i]) &&
          (!best_ok || local_priority_field[i] < local_priority_field[best]))
      begin
        best = 2'(i); // strict compare keeps the lower index on ties [R10] [R23]
        best_ok = 1'b1;
      end
    end
    // transmit sequencer
    case (tx_state)
      TX_IDLE: begin
        if (arb_slot && best_ok) begin
          next_tx_state = TX_BUSY; // each retry arbitrates again [R10]
          next_cur_idx = best;
          next_offer.valid = 1'b1;
          next_offer.idx = best;
          next_offer.frame = {tx_mem[best][3][7:0], tx_mem[best][2],
                              tx_mem[best][1], tx_mem[best][0]};
        end
      end
      TX_BUSY: begin
        if (tx_sent) begin
          next_tx_state = TX_IDLE;
          next_offer.valid = 1'b0;
          set_empty[cur_idx] = 1'b1; // [R9]
          next_abort_ack[cur_idx] = 1'b0; // sent, not cancelled [R12]
          next_abort_req[cur_idx] = 1'b0;
          if (ctrl.stamp_en) begin
            next_tx_stamp[cur_idx] = timer; // [R1]
          end
        end else if (tx_retry) begin
          // lost or errored: stay pending, receive the winner [R21]
          next_tx_state = TX_IDLE;
          next_offer.valid = 1'b0;
        end
      end
      default: begin
        next_tx_state = TX_IDLE;
        next_offer.valid = 1'b0;
      end
    endcase
    // abort is granted for every pending buffer not on the bus
    for (int i = 0; i < 3; i++) begin
      if (abort_request_bit[i] && !tx_buffer_empty_flag[i] &&
          !(tx_state == TX_BUSY && cur_idx == 2'(i))) begin
        set_empty[i] = 1'b1; // [R11]
        next_abort_ack[i] = 1'b1; // [R12]
        next_abort_req[i] = 1'b0;
      end
    end
    next_empty = next_empty | set_empty; // hardware set wins over clear
    // background entry is filled byte by byte while filtering runs
    if (rx_byte.valid && rx_byte.idx < 4'(`TX_FRAME_BYTES)) begin
      next_bg[rx_byte.idx] = rx_byte.data; // [R16]
    end
    // only good, accepted, foreign (or looped) frames move on [R18]
    if (rx_frame_ok && rx_accept && (!rx_own || ctrl.loopback)) begin // [R19] [R20]
      if (count == `RX_DEPTH) begin
        drop = 1'b1; // [R22]
      end else begin
        push = 1'b1; // [R16]
      end
    end
    if (push) begin
      for (int b = 0; b < `TX_FRAME_BYTES; b++) begin
        next_fifo[wr_ptr].frame[8*b +: 8] = rx_background_entry[b];
      end
      next_fifo[wr_ptr].stamp = ctrl.stamp_en ? timer : 16'h0000; // [R1] [R14]
      next_wr_ptr = ptr_inc(wr_ptr);
    end
    if (pop) begin
      next_rd_ptr = ptr_inc(rd_ptr);
    end
    next_count = count + {2'b00, push} - {2'b00, pop};
    if (drop) begin
      next_overrun = 1'b1; // set wins over a clear in the same cycle [R22]
    end
    next_tx_event = ctrl.tx_ie && (|set_empty); // [R9] [R11]
    next_rx_event = ctrl.rx_ie && push; // [R16]
    next_ovr_event = ctrl.ovr_ie && drop; // [R22]
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= ctrl_raw_t'(`CTRL_RST);
      tx_buffer_empty_flag <= `TX_EMPTY_RST;
      abort_request_bit <= 3'h0;
      abort_ack_flag <= 3'h0;
      tx_buffer_select_reg <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        for (int k = 0; k < 4; k++) begin
          tx_mem[i][k] <= 32'h0000_0000;
        end
        local_priority_field[i] <= 8'h00;
        tx_stamp[i] <= 16'h0000;
      end
      tx_state <= TX_IDLE;
      cur_idx <= 2'h0;
      tx_offer <= '0;
      timer <= 16'h0000;
      for (int b = 0; b < 13; b++) begin
        rx_background_entry[b] <= 8'h00;
      end
      for (int e = 0; e < 5; e++) begin
        fifo[e] <= '0;
      end
      rd_ptr <= 3'h0;
      wr_ptr <= 3'h0;
      count <= 3'h0;
      overrun_flag <= 1'b0;
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
      tx_event <= 1'b0;
      rx_event <= 1'b0;
      overrun_event <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      tx_buffer_empty_flag <= next_empty;
      abort_request_bit <= next_abort_req;
      abort_ack_flag <= next_abort_ack;
      tx_buffer_select_reg <= next_sel;
      tx_mem <= next_tx_mem;
      local_priority_field <= next_local_priority_field;
      tx_stamp <= next_tx_stamp;
      tx_state <= next_tx_state;
      cur_idx <= next_cur_idx;
      tx_offer <= next_offer;
      timer <= next_timer;
      rx_background_entry <= next_bg;
      fifo <= next_fifo;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
      overrun_flag <= next_overrun;
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      tx_event <= next_tx_event;
      rx_event <= next_rx_event;
      overrun_event <= next_ovr_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire busy_sent = (tx_state == TX_BUSY) && tx_sent;
  wire fg_pop = wr_fire && ({aw_addr[7:2], 2'b00} == `OFS_RX_FLAG) &&
                w_strb[0] && w_data[`RX_FULL_BIT] && rx_full_flag;

  a_timer_init_zero: assert property (ctrl.init_mode |=> timer == 16'h0000) // [R4]
    else $error("timer not held at zero in init mode");
  a_timer_wrap: assert property (!ctrl.init_mode && bit_tick &&
    timer == 16'hffff ##1 !ctrl.init_mode |-> timer == 16'h0000) // [R3]
    else $error("timer did not wrap to zero");
  a_sent_empty: assert property (busy_sent |=> tx_buffer_empty_flag[$past(cur_idx)] // [R9]
    && tx_state == TX_IDLE) else $error("sent buffer not released");
  a_sent_ack_low: assert property (busy_sent |=> !abort_ack_flag[$past(cur_idx)]) // [R12]
    else $error("abort ack set on a sent buffer");
  a_abort_grant: assert property (abort_request_bit[0] && !tx_buffer_empty_flag[0] // [R11]
    && !(tx_state == TX_BUSY && cur_idx == 2'h0) |=> tx_buffer_empty_flag[0]
    && abort_ack_flag[0] && !abort_request_bit[0]) else $error("abort not granted");
  a_tx_stamp: assert property (busy_sent && ctrl.stamp_en |=> // [R1]
    tx_stamp[$past(cur_idx)] == $past(timer)) else $error("tx stamp wrong");
  a_local_priority_field_pick: assert property (tx_state == TX_IDLE && arb_slot && // [R10]
    !tx_buffer_empty_flag[1] && !abort_request_bit[1] && !tx_buffer_empty_flag[0]
    && !abort_request_bit[0] |=> tx_offer.valid && local_priority_field[tx_offer.idx]
    <= local_priority_field[1] && (tx_offer.idx != 2'h1 || local_priority_field[1]
    < local_priority_field[0])) else $error("wrong buffer won arbitration");
  a_push_full_flag: assert property (rx_frame_ok && rx_accept && !rx_own && // [R15]
    count == 3'h0 |=> rx_full_flag ##1 (rx_full_flag || $past(fg_pop)))
    else $error("rx full flag missing after push");
  a_reject_no_push: assert property (rx_frame_ok && !rx_accept && !fg_pop // [R18]
    |=> $stable(count)) else $error("rejected frame entered fifo");
  a_own_no_push: assert property (rx_frame_ok && rx_own && !ctrl.loopback && // [R19]
    !fg_pop |=> $stable(count) && !rx_event) else $error("own frame pushed");
  a_overrun_drop: assert property (rx_frame_ok && rx_accept && !rx_own && // [R22]
    count == `RX_DEPTH && !fg_pop |=> count == `RX_DEPTH && overrun_flag
    && $stable(wr_ptr)) else $error("overrun not handled");
  c_sent: cover property (busy_sent ##1 tx_event);
  c_abort: cover property (abort_request_bit != 3'h0 ##1 abort_ack_flag != 3'h0);
  c_overrun: cover property (overrun_event);
  c_fifo_full: cover property (count == `RX_DEPTH ##[1:20] fg_pop);
endmodule

// ---- testbench/can_bus_model.sv ----
// bus-side engine model: bit ticks, arbitration answers, incoming frames
`timescale 1ns/1ps
module can_bus_model import can_msgbuf_pkg::*; (
  input wire logic aclk,
  input wire tx_offer_t tx_offer,
  output logic bit_tick,
  output logic arb_slot,
  output logic tx_sent,
  output logic tx_retry,
  output rx_byte_t rx_byte,
  output logic rx_frame_ok,
  output logic rx_accept,
  output logic rx_own
);
  logic [1:0] cnt = 2'h0;
  initial {bit_tick, arb_slot, tx_sent, tx_retry, rx_byte} = '0;
  initial {rx_frame_ok, rx_accept, rx_own} = '0;
  // four clocks per bit time keep the stamp timer moving
  always @(posedge aclk) begin
    cnt <= cnt + 2'h1;
    bit_tick <= (cnt == 2'h3);
  end
  //////////////////////////////////////////////////////////////////////
  // open a slot, take the offer, end it sent or lost wt + 1 cycles after the offer is seen
  task automatic arb(input logic retry, input int wt, output tx_offer_t o);
    int n;
    arb_slot <= 1'b1;
    @(posedge aclk) arb_slot <= 1'b0;
    n = 0;
    o = '0;
    while (!o.valid && n < 20) begin
      @(negedge aclk) o = tx_offer;
      n++;
    end
    repeat (wt + 1) @(posedge aclk);
    tx_retry <= retry;
    tx_sent <= !retry;
    @(posedge aclk);
    tx_retry <= 1'b0;
    tx_sent <= 1'b0;
  endtask
  // bytes in index order, then the end-of-frame strobe
  task automatic send(input logic [103:0] f, input logic acc, own);
    for (int b = 0; b < 13; b++) begin
      rx_byte <= '{1'b1, 4'(b), f[8*b+:8]};
      @(posedge aclk);
    end
    rx_byte <= '0;
    rx_frame_ok <= 1'b1;
    rx_accept <= acc;
    rx_own <= own;
    @(posedge aclk);
    rx_frame_ok <= 1'b0;
  endtask
endmodule

// ---- testbench/can_message_buffer_manager_tb.sv ----
// self-checking bench of the message buffer manager
`timescale 1ns/1ps
`include "can_msgbuf_params.svh"
`define CMP(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module can_message_buffer_manager_tb;
  import can_msgbuf_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, bit_tick, arb_slot, tx_sent, tx_retry;
  logic rx_frame_ok, rx_accept, rx_own;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, e;
  logic [31:0] s_axi_rdata, d, w [3];
  rx_byte_t rx_byte;
  tx_offer_t tx_offer, o;
  int n_errors = 0, n_checks = 0;
  logic [7:0] p [3];
  logic [103:0] f [6];
  logic [2:0] pend;
  logic tx_ev, rx_ev, ov_ev, ack_en;
  int n_tx = 0, n_rx = 0, n_ov = 0, n_busy = 0;
  can_message_buffer_manager u_can_message_buffer_manager (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bit_tick,
    .arb_slot, .tx_sent, .tx_retry, .rx_byte, .rx_frame_ok, .rx_accept,
    .rx_own, .tx_offer, .rx_ack_enable(ack_en), .tx_event(tx_ev),
    .rx_event(rx_ev), .overrun_event(ov_ev));
  can_bus_model u_can_bus_model (.aclk, .tx_offer, .bit_tick, .arb_slot,
    .tx_sent, .tx_retry, .rx_byte, .rx_frame_ok, .rx_accept, .rx_own);
  // 125 MHz clock
  initial forever #4 aclk = ~aclk;
  // pulses counted mid-cycle, where they have settled after the edge
  always @(negedge aclk) if (aresetn) begin
    n_tx += tx_ev;
    n_rx += rx_ev;
    n_ov += ov_ev;
    n_busy += !ack_en;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // a wait that runs out counts once and ends the run
  task automatic bound(input int n);
    if (n > 40) begin
      n_errors++;
      summarize();
    end
  endtask
  // readiness is sampled mid-cycle, so it equals its value at the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    tb = 0;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
      bound(n);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    int n;
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    tr = 0;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
      bound(n);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] v;
    logic [1:0] r;
    rd(a, v, r);
    `CMP("read data", x, v)
  endtask
  // lowest priority value wins, ties go to the lower index
  function automatic logic [1:0] pick(input logic [2:0] m);
    logic [1:0] b;
    b = 2'h3;
    for (int i = 0; i < 3; i++)
      if (m[i] && (b == 2'h3 || p[i] < p[b])) b = 2'(i);
    return b;
  endfunction
  //////////////////////////////////////////////////////////////////////
  // main sequence: reset, registers, transmit order, abort, receive fifo
  initial begin
    void'($urandom(58));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(`OFS_TX_FLAG, 32'h7);
    chk(`OFS_CTRL, 32'h1);
    rd(8'h30, d, rsp);
    `CMP("rresp", `RESP_SLVERR, rsp)
    wr(`OFS_CTRL, 32'h3a);
    wr(`OFS_TX_SELECT, 32'h1);
    wr(`OFS_STAMP_LOW, 32'hff);
    chk(`OFS_STAMP_LOW, 32'h0);
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 3; i++) begin
        p[i] = (r == 0) ? 8'h40 : 8'($urandom);
        w[i] = $urandom;
        wr(`OFS_TX_SELECT, 32'(1 << i));
        wr(`OFS_TX_LOCAL_PRIORITY_FIELD, {24'h0, p[i]});
        wr(`OFS_TX_WIN, w[i]);
      end
      wr(`OFS_TX_FLAG, 32'h7);
      pend = 3'h7;
      for (int k = 0; k < 3; k++) begin
        e = pick(pend);
        if (k == r) begin
          u_can_bus_model.arb(1'b1, 0, o);
          `CMP("retry idx", {1'b1, e}, {o.valid, o.idx})
        end
        u_can_bus_model.arb(1'b0, k, o);
        `CMP("offer idx", {1'b1, e}, {o.valid, o.idx})
        `CMP("frame", w[e], o.frame[31:0])
        pend[e] = 1'b0;
        chk(`OFS_TX_FLAG, {29'h0, ~pend});
        chk(`OFS_ABORT_ACK, 32'h0);
      end
    end
    wr(`OFS_TX_SELECT, 32'h1);
    wr(`OFS_TX_FLAG, 32'h1);
    wr(`OFS_ABORT_REQ, 32'h1);
    chk(`OFS_ABORT_ACK, 32'h1);
    chk(`OFS_TX_FLAG, 32'h7);
    f[0] = {72'h0, $urandom};
    u_can_bus_model.send(f[0], 1'b0, 1'b0);
    chk(`OFS_RX_FLAG, 32'h0);
    u_can_bus_model.send(f[0], 1'b1, 1'b1);
    chk(`OFS_RX_FLAG, 32'h0);
    for (int j = 0; j < 6; j++) begin
      f[j] = {72'h0, $urandom};
      u_can_bus_model.send(f[j], 1'b1, 1'b0);
    end
    chk(`OFS_RX_FLAG, 32'h3);
    for (int j = 0; j < 5; j++) begin
      chk(`OFS_RX_WIN, f[j][31:0]);
      wr(`OFS_RX_FLAG, 32'h1);
    end
    chk(`OFS_RX_FLAG, 32'h2);
    // loopback: an own frame is stored like a foreign one
    wr(`OFS_CTRL, 32'h3e);
    u_can_bus_model.send(f[5], 1'b1, 1'b1);
    chk(`OFS_RX_WIN, f[5][31:0]);
    `CMP("tx events", 10, n_tx)
    `CMP("rx events", 6, n_rx)
    `CMP("overrun events", 1, n_ov)
    `CMP("busy cycles", 33, n_busy)
    summarize();
  end
  // cuts a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    summarize();
  end
endmodule
